// ===== inc/psu_pkg.sv
// Constants and types of the bus command slave.
// Assumes a 10 MHz system clock; bus pins are asynchronous.
`default_nettype none

package psu_pkg;

   // ==========================================================
   // Clock and fan timing
   localparam int unsigned PSU_CLK_HZ       = 10_000_000;
   localparam int unsigned PSU_FAN_WARN_S   = 30;
   localparam int unsigned PSU_FAN_WARN_CYC = PSU_FAN_WARN_S * PSU_CLK_HZ;

   // ==========================================================
   // Bus command codes
   localparam logic [7:0] PSU_CMD_FAN_STATUS = 8'h81;
   localparam logic [7:0] PSU_CMD_VCAP       = 8'h8A;
   localparam logic [7:0] PSU_CMD_VOUT       = 8'h8B;
   localparam logic [7:0] PSU_CMD_IOUT       = 8'h8C;
   localparam logic [7:0] PSU_CMD_TEMP       = 8'h8D;
   localparam logic [7:0] PSU_CMD_PROTO_REV  = 8'h98;
   localparam logic [7:0] PSU_CMD_ID_MAKER   = 8'h99;
   localparam logic [7:0] PSU_CMD_ID_MODEL   = 8'h9A;
   localparam logic [7:0] PSU_CMD_ID_REV     = 8'h9B;
   localparam logic [7:0] PSU_CMD_ID_SERIAL  = 8'h9E;
   localparam logic [7:0] PSU_CMD_FAN_SUPPLY = 8'hD0;
   localparam logic [7:0] PSU_CMD_TRIM_VOUT  = 8'hE4;
   localparam logic [7:0] PSU_CMD_TRIM_ILIM  = 8'hE5;

   // ==========================================================
   // Trim range, fan status bits, defaults
   localparam logic [7:0] PSU_TRIM_MAX      = 8'h65;
   localparam logic [7:0] PSU_TRIM_NOMINAL  = 8'h32;
   localparam int unsigned PSU_FAN_WARN_BIT = 5;
   localparam int unsigned PSU_FAN_FAIL_BIT = 7;
   localparam logic [6:0] PSU_ADDR_RST      = 7'h58;
   localparam logic [7:0] PSU_REV_RST       = 8'h11;
   localparam logic [7:0] PSU_NO_DATA       = 8'hFF;

   // Identity strings, eight characters each; contents are arbitrary
   localparam logic [7:0]  PSU_ID_LEN    = 8'h08;
   localparam logic [63:0] PSU_ID_MAKER  = "GENMAKER";
   localparam logic [63:0] PSU_ID_MODEL  = "MODEL001";
   localparam logic [63:0] PSU_ID_REV    = "REV00001";
   localparam logic [63:0] PSU_ID_SERIAL = "SN000001";

   // ==========================================================
   // Register map (byte offsets)
   localparam logic [4:0] PSU_REG_TEL_VOUT = 5'h00;
   localparam logic [4:0] PSU_REG_TEL_IOUT = 5'h04;
   localparam logic [4:0] PSU_REG_TEL_TEMP = 5'h08;
   localparam logic [4:0] PSU_REG_TEL_VCAP = 5'h0C;
   localparam logic [4:0] PSU_REG_TEL_VFAN = 5'h10;
   localparam logic [4:0] PSU_REG_CONFIG   = 5'h14;
   localparam logic [4:0] PSU_REG_STATUS   = 5'h18;
   localparam logic [4:0] PSU_REG_REVISION = 5'h1C;
   localparam int unsigned PSU_STAT_TRIMV_LSB = 8;
   localparam int unsigned PSU_STAT_TRIMI_LSB = 16;

   // Telemetry slots
   localparam logic [2:0] PSU_TEL_VOUT = 3'h0;
   localparam logic [2:0] PSU_TEL_IOUT = 3'h1;
   localparam logic [2:0] PSU_TEL_TEMP = 3'h2;
   localparam logic [2:0] PSU_TEL_VCAP = 3'h3;
   localparam logic [2:0] PSU_TEL_VFAN = 3'h4;

   // ==========================================================
   // Serial engine states
   typedef enum logic [3:0] {
      PSU_IDLE   = 4'h0,
      PSU_ADDR   = 4'h1,
      PSU_ACK    = 4'h2,
      PSU_CMD    = 4'h3,
      PSU_WDATA  = 4'h4,
      PSU_TX     = 4'h5,
      PSU_MACK   = 4'h6,
      PSU_IGNORE = 4'h7
   } psu_i2c_e;

   // Whole state of the block
   typedef struct packed {
      logic [2:0]        scl_p;
      logic [2:0]        sda_p;
      logic [1:0]        fan_p;
      psu_i2c_e          st;
      psu_i2c_e          ack_nxt;
      logic [3:0]        cnt;
      logic [7:0]        sh;
      logic [7:0]        cmd;
      logic [7:0]        idx;
      logic [15:0]       word;
      logic              sda_oe;
      logic [7:0]        trim_v;
      logic [7:0]        trim_i;
      logic              nv_wr_v;
      logic              nv_wr_i;
      logic              restored;
      logic [31:0]       fan_cnt;
      logic [7:0]        fan_stat;
      logic [4:0][15:0]  tel;
      logic [6:0]        own_addr;
      logic [7:0]        rev;
      logic              ahb_act;
      logic              ahb_wr;
      logic [4:0]        ahb_off;
      logic [31:0]       rdata;
      logic              hready;
   } psu_state_s;

endpackage : psu_pkg

`default_nettype wire

// ===== core/psu_cmd_slave.sv
// Bus command slave of a supervised power supply: serial slave engine,
// fan fault timers, trims with restore, and an AHB-Lite register file.
// Assumes SCL/SDA and the fan fault pin are asynchronous to CLK_SYS and
// that the non-volatile store presents its saved trims at reset release.
`default_nettype none

// Overview of operation
// - Master sends an 8-bit command code; device acknowledges it.
// - Voltage, current, fan supply, temperature and fan status are readable.
// - Output trim covers +/-10% and current limit 0 to 110%.
// - Codes 8Bh, 8Ch, 8Dh return two-byte words.
// - Codes 8Ah and D0h return two-byte words like voltage reads.
// - Code 81h returns one fan status byte.
// - Code 98h returns one protocol revision byte.
// - Codes 99h, 9Ah, 9Bh, 9Eh return identity strings as block reads.
// - Codes E4h and E5h accept one data byte as write-byte.
// - Read byte: repeated start, read address, one byte, master does not ack, stop.
// - Read word: low byte first, acked by master, then high byte, not acked.
// - Block read: count N first, then N data bytes.
// - Fan warning after 30 s continuous fault, failure after 30 s more.
// - Normal fan gives an all-zero status byte.
// - Warning sets bit 5, byte reads 20h.
// - Failure sets bit 7 with warning kept, byte reads A0h.
// - Last written trims are kept in non-volatile store and restored.
// - Output trim accepts 0 to 65h; larger values become 65h.
// - Trim 0 is minimum, 65h maximum; default is nominal.
// - Current limit trim 0 to 65h, larger values saturate to 65h.
// - Device answers only its own 7-bit address.
module psu_cmd_slave
   import psu_pkg::*;
#(
   parameter int unsigned FAN_WARN_CYC = PSU_FAN_WARN_CYC
) (
   // Clock and reset
   input  wire logic        CLK_SYS,
   input  wire logic        RST_N,
   // Serial bus pins (open drain)
   input  wire logic        SCL_I,
   input  wire logic        SDA_I,
   output var  logic        SDA_O,
   output var  logic        SDA_OE,
   // Fan tacho fault, high while the tacho reports a fault
   input  wire logic        FAN_FAULT,
   // Non-volatile trim store
   input  wire logic [7:0]  NV_TRIM_VOUT,
   input  wire logic [7:0]  NV_TRIM_ILIM,
   output var  logic        NV_WR_VOUT,
   output var  logic        NV_WR_ILIM,
   // Trims to the regulation references
   output var  logic [7:0]  TRIM_VOUT,
   output var  logic [7:0]  TRIM_ILIM,
   // AHB-Lite slave
   input  wire logic        HSEL,
   input  wire logic [31:0] HADDR,
   input  wire logic [1:0]  HTRANS,
   input  wire logic        HWRITE,
   input  wire logic [2:0]  HSIZE,
   input  wire logic [31:0] HWDATA,
   input  wire logic        HREADY,
   output var  logic [31:0] HRDATA,
   output var  logic        HREADYOUT,
   output var  logic        HRESP
);

   // ==========================================================
   // Helper functions

   // Clamp a written trim to the top of its range
   function automatic logic [7:0] sat_trim(input logic [7:0] v);
      sat_trim = (v > PSU_TRIM_MAX) ? PSU_TRIM_MAX : v;
   endfunction : sat_trim

   // Command answered with read data
   function automatic logic is_read_cmd(input logic [7:0] c);
      case (c)
         PSU_CMD_FAN_STATUS, PSU_CMD_VCAP, PSU_CMD_VOUT, PSU_CMD_IOUT,
         PSU_CMD_TEMP, PSU_CMD_PROTO_REV, PSU_CMD_ID_MAKER, PSU_CMD_ID_MODEL,
         PSU_CMD_ID_REV, PSU_CMD_ID_SERIAL, PSU_CMD_FAN_SUPPLY: is_read_cmd = 1'b1;
         default: is_read_cmd = 1'b0;
      endcase
   endfunction : is_read_cmd

   // Telemetry slot behind a word command
   function automatic logic [2:0] tel_slot(input logic [7:0] c);
      case (c)
         PSU_CMD_VOUT:       tel_slot = PSU_TEL_VOUT;
         PSU_CMD_IOUT:       tel_slot = PSU_TEL_IOUT;
         PSU_CMD_TEMP:       tel_slot = PSU_TEL_TEMP;
         PSU_CMD_VCAP:       tel_slot = PSU_TEL_VCAP;
         PSU_CMD_FAN_SUPPLY: tel_slot = PSU_TEL_VFAN;
         default:            tel_slot = PSU_TEL_VOUT;
      endcase
   endfunction : tel_slot

   // Identity char k, leftmost first
   function automatic logic [7:0] id_char(input logic [63:0] s, input logic [7:0] k);
      logic [63:0] t;
      t       = s << {k[2:0], 3'b000};
      id_char = t[63:56];
   endfunction : id_char

   // Byte number idx of the answer to command c
   function automatic logic [7:0] tx_byte(input logic [7:0]  c,
                                          input logic [7:0]  idx,
                                          input logic [15:0] w,
                                          input logic [7:0]  fan,
                                          input logic [7:0]  rev);
      logic [7:0] k;
      k       = idx - 8'h01;
      tx_byte = PSU_NO_DATA;
      case (c)
         PSU_CMD_FAN_STATUS: tx_byte = (idx == 8'h00) ? fan : PSU_NO_DATA;
         PSU_CMD_PROTO_REV:  tx_byte = (idx == 8'h00) ? rev : PSU_NO_DATA;
         PSU_CMD_VOUT, PSU_CMD_IOUT, PSU_CMD_TEMP, PSU_CMD_VCAP, PSU_CMD_FAN_SUPPLY: begin
            // Low byte first, then high byte
            if (idx == 8'h00) begin
               tx_byte = w[7:0];
            end else if (idx == 8'h01) begin
               tx_byte = w[15:8];
            end
         end
         PSU_CMD_ID_MAKER, PSU_CMD_ID_MODEL, PSU_CMD_ID_REV, PSU_CMD_ID_SERIAL: begin
            // Count first, then the characters
            if (idx == 8'h00) begin
               tx_byte = PSU_ID_LEN;
            end else if (idx <= PSU_ID_LEN) begin
               case (c)
                  PSU_CMD_ID_MAKER: tx_byte = id_char(PSU_ID_MAKER, k);
                  PSU_CMD_ID_MODEL: tx_byte = id_char(PSU_ID_MODEL, k);
                  PSU_CMD_ID_REV:   tx_byte = id_char(PSU_ID_REV, k);
                  default:          tx_byte = id_char(PSU_ID_SERIAL, k);
               endcase
            end
         end
         default: tx_byte = PSU_NO_DATA;
      endcase
   endfunction : tx_byte

   // ==========================================================
   // State and next state
   psu_state_s s_q;
   psu_state_s s_d;

   logic scl_rise;
   logic scl_fall;
   logic bus_start;
   logic bus_stop;
   logic sda_bit;
   logic fan_bad;
   logic [7:0]  tb;
   logic [31:0] rd;

   // Edges from flops two and three only
   assign scl_rise  = s_q.scl_p[1] & ~s_q.scl_p[2];
   assign scl_fall  = ~s_q.scl_p[1] & s_q.scl_p[2];
   assign bus_start = s_q.scl_p[1] & s_q.scl_p[2] & s_q.sda_p[2] & ~s_q.sda_p[1];
   assign bus_stop  = s_q.scl_p[1] & s_q.scl_p[2] & ~s_q.sda_p[2] & s_q.sda_p[1];
   assign sda_bit   = s_q.sda_p[1];
   assign fan_bad   = s_q.fan_p[1];

   // ==========================================================
   // Next-state logic
   always_comb begin
      s_d = s_q;
      tb  = 8'h00;
      rd  = 32'h0000_0000;

      // Pin synchronisers
      s_d.scl_p = {s_q.scl_p[1:0], SCL_I};
      s_d.sda_p = {s_q.sda_p[1:0], SDA_I};
      s_d.fan_p = {s_q.fan_p[0], FAN_FAULT};

      // Store strobes last one cycle
      s_d.nv_wr_v = 1'b0;
      s_d.nv_wr_i = 1'b0;

      // Saved trims load once after reset
      if (!s_q.restored) begin
         s_d.trim_v   = sat_trim(NV_TRIM_VOUT);
         s_d.trim_i   = sat_trim(NV_TRIM_ILIM);
         s_d.restored = 1'b1;
      end

      // Fan timer: any healthy sample restarts the count
      if (fan_bad) begin
         if (s_q.fan_cnt < 32'(2 * FAN_WARN_CYC)) begin
            s_d.fan_cnt = s_q.fan_cnt + 32'h0000_0001;
         end
      end else begin
         s_d.fan_cnt = 32'h0000_0000;
      end
      s_d.fan_stat = 8'h00;
      s_d.fan_stat[PSU_FAN_WARN_BIT] = (s_q.fan_cnt >= 32'(FAN_WARN_CYC));
      s_d.fan_stat[PSU_FAN_FAIL_BIT] = (s_q.fan_cnt >= 32'(2 * FAN_WARN_CYC));

      // ---------------- Serial engine ----------------
      tb = tx_byte(s_q.cmd, s_q.idx, s_q.word, s_q.fan_stat, s_q.rev);
      if (bus_stop) begin
         s_d.st     = PSU_IDLE;
         s_d.sda_oe = 1'b0;
      end else if (bus_start) begin
         // Start or Sr; command kept for the read
         s_d.st     = PSU_ADDR;
         s_d.cnt    = 4'h0;
         s_d.sda_oe = 1'b0;
      end else if (scl_rise) begin
         case (s_q.st)
            PSU_ADDR, PSU_CMD, PSU_WDATA: begin
               s_d.sh  = {s_q.sh[6:0], sda_bit};
               s_d.cnt = s_q.cnt + 4'h1;
            end
            PSU_MACK: s_d.sh[0] = sda_bit;             // Master ack, low means more
            default: ;
         endcase
      end else if (scl_fall) begin
         case (s_q.st)
            PSU_ADDR: begin
               if (s_q.cnt == 4'h8) begin
                  if (s_q.sh[7:1] != s_q.own_addr) begin
                     s_d.st = PSU_IGNORE;
                  end else if (!s_q.sh[0]) begin
                     s_d.st      = PSU_ACK;
                     s_d.ack_nxt = PSU_CMD;
                     s_d.sda_oe  = 1'b1;
                  end else if (is_read_cmd(s_q.cmd)) begin
                     // Snapshot keeps low and high byte consistent
                     s_d.st      = PSU_ACK;
                     s_d.ack_nxt = PSU_TX;
                     s_d.sda_oe  = 1'b1;
                     s_d.idx     = 8'h00;
                     s_d.word    = s_q.tel[tel_slot(s_q.cmd)];
                  end else begin
                     s_d.st = PSU_IGNORE;
                  end
                  s_d.cnt = 4'h0;
               end
            end
            PSU_CMD: begin
               if (s_q.cnt == 4'h8) begin
                  s_d.cmd     = s_q.sh;
                  s_d.st      = PSU_ACK;
                  s_d.ack_nxt = PSU_WDATA;
                  s_d.sda_oe  = 1'b1;
                  s_d.cnt     = 4'h0;
               end
            end
            PSU_WDATA: begin
               if (s_q.cnt == 4'h8) begin
                  // Any code's data byte is acked; only the two trim codes use it
                  if (s_q.cmd == PSU_CMD_TRIM_VOUT) begin
                     s_d.trim_v  = sat_trim(s_q.sh);
                     s_d.nv_wr_v = 1'b1;
                  end else if (s_q.cmd == PSU_CMD_TRIM_ILIM) begin
                     s_d.trim_i  = sat_trim(s_q.sh);
                     s_d.nv_wr_i = 1'b1;
                  end
                  s_d.st      = PSU_ACK;
                  s_d.ack_nxt = PSU_IGNORE;
                  s_d.sda_oe  = 1'b1;
                  s_d.cnt     = 4'h0;
               end
            end
            PSU_ACK: begin
               s_d.st = s_q.ack_nxt;
               if (s_q.ack_nxt == PSU_TX) begin
                  // First data bit goes out on the same falling edge
                  s_d.sh     = {tb[6:0], 1'b0};
                  s_d.sda_oe = ~tb[7];
                  s_d.cnt    = 4'h1;
               end else begin
                  s_d.sda_oe = 1'b0;
               end
            end
            PSU_TX: begin
               if (s_q.cnt == 4'h8) begin
                  s_d.sda_oe = 1'b0;                   // Release for master ack
                  s_d.st     = PSU_MACK;
               end else begin
                  s_d.sda_oe = ~s_q.sh[7];
                  s_d.sh     = {s_q.sh[6:0], 1'b0};
                  s_d.cnt    = s_q.cnt + 4'h1;
               end
            end
            PSU_MACK: begin
               if (!s_q.sh[0]) begin
                  // Acked: next byte; answers past the end read FFh
                  s_d.idx = s_q.idx + 8'h01;
                  s_d.st  = PSU_TX;
                  s_d.cnt = 4'h1;
                  // Next byte loads now; its first bit
                  // leaves on this same falling edge
                  s_d.sh  = tx_byte(s_q.cmd, s_q.idx + 8'h01, s_q.word,
                                    s_q.fan_stat, s_q.rev);
                  s_d.sda_oe = ~s_d.sh[7];
                  s_d.sh  = {s_d.sh[6:0], 1'b0};
               end else begin
                  s_d.st = PSU_IGNORE;
               end
            end
            default: ;
         endcase
      end

      // ---------------- AHB-Lite data phase ----------------
      if (s_q.ahb_act && s_q.ahb_wr) begin
         case (s_q.ahb_off)
            PSU_REG_TEL_VOUT: s_d.tel[PSU_TEL_VOUT] = HWDATA[15:0];
            PSU_REG_TEL_IOUT: s_d.tel[PSU_TEL_IOUT] = HWDATA[15:0];
            PSU_REG_TEL_TEMP: s_d.tel[PSU_TEL_TEMP] = HWDATA[15:0];
            PSU_REG_TEL_VCAP: s_d.tel[PSU_TEL_VCAP] = HWDATA[15:0];
            PSU_REG_TEL_VFAN: s_d.tel[PSU_TEL_VFAN] = HWDATA[15:0];
            PSU_REG_CONFIG:   s_d.own_addr = HWDATA[6:0];
            PSU_REG_REVISION: s_d.rev = HWDATA[7:0];
            default: ;
         endcase
      end

      // ---------------- AHB-Lite address phase ----------------
      // Reads see this cycle's writes
      s_d.ahb_act = HSEL & HTRANS[1] & HREADY;
      s_d.ahb_wr  = HWRITE;
      s_d.ahb_off = (HADDR[31:5] == 27'h0) ? HADDR[4:0] : 5'h03;
      case (s_d.ahb_off)
         PSU_REG_TEL_VOUT: rd[15:0] = s_d.tel[PSU_TEL_VOUT];
         PSU_REG_TEL_IOUT: rd[15:0] = s_d.tel[PSU_TEL_IOUT];
         PSU_REG_TEL_TEMP: rd[15:0] = s_d.tel[PSU_TEL_TEMP];
         PSU_REG_TEL_VCAP: rd[15:0] = s_d.tel[PSU_TEL_VCAP];
         PSU_REG_TEL_VFAN: rd[15:0] = s_d.tel[PSU_TEL_VFAN];
         PSU_REG_CONFIG:   rd[6:0]  = s_d.own_addr;
         PSU_REG_STATUS: begin
            rd[7:0] = s_d.fan_stat;
            rd[PSU_STAT_TRIMV_LSB +: 8] = s_d.trim_v;
            rd[PSU_STAT_TRIMI_LSB +: 8] = s_d.trim_i;
         end
         PSU_REG_REVISION: rd[7:0] = s_d.rev;
         default: rd = 32'h0000_0000;
      endcase
      s_d.rdata  = (s_d.ahb_act && !HWRITE) ? rd : 32'h0000_0000;
      s_d.hready = 1'b1;                               // Zero wait states
   end

   // ==========================================================
   // State register
   always_ff @(posedge CLK_SYS) begin
      if (!RST_N) begin
         s_q          <= '0;
         s_q.scl_p    <= 3'h7;
         s_q.sda_p    <= 3'h7;
         s_q.st       <= PSU_IDLE;
         s_q.ack_nxt  <= PSU_IDLE;
         s_q.trim_v   <= PSU_TRIM_NOMINAL;
         s_q.trim_i   <= PSU_TRIM_MAX;
         s_q.own_addr <= PSU_ADDR_RST;
         s_q.rev      <= PSU_REV_RST;
         s_q.hready   <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   // ==========================================================
   // Outputs, from state flops except the tied-off SDA_O and HRESP
   always_comb begin
      SDA_O      = 1'b0;                  // Open drain: only the enable moves
      SDA_OE     = s_q.sda_oe;
      NV_WR_VOUT = s_q.nv_wr_v;
      NV_WR_ILIM = s_q.nv_wr_i;
      TRIM_VOUT  = s_q.trim_v;
      TRIM_ILIM  = s_q.trim_i;
      HRDATA     = s_q.rdata;
      HREADYOUT  = s_q.hready;
      HRESP      = 1'b0;                  // Always OKAY
   end

endmodule : psu_cmd_slave

`default_nettype wire

// ===== verif/psu_cmd_props.sv
// Port checker of the bus command slave.
// Bound into psu_cmd_slave; watches its ports only.
`default_nettype none
// ==========================================
// Checker
module psu_cmd_props (
   // Watched ports
   input wire logic        CLK_SYS,
   input wire logic        RST_N,
   input wire logic        SCL_I,
   input wire logic        SDA_O,
   input wire logic        SDA_OE,
   input wire logic [7:0]  NV_TRIM_VOUT,
   input wire logic        NV_WR_VOUT,
   input wire logic [7:0]  TRIM_VOUT,
   input wire logic [7:0]  TRIM_ILIM,
   input wire logic        HSEL,
   input wire logic [1:0]  HTRANS,
   input wire logic        HWRITE,
   input wire logic        HREADY,
   input wire logic [31:0] HRDATA,
   input wire logic        HREADYOUT,
   input wire logic        HRESP
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (!RST_N);
   // No read taken this cycle
   sequence s_no_rd;
      !(HSEL && HTRANS[1] && HREADY && !HWRITE);
   endsequence
   // Strobe then low
   sequence s_nv_strobe;
      $rose(NV_WR_VOUT) ##1 !NV_WR_VOUT;
   endsequence
   a_trim_v_cap: assert property (TRIM_VOUT <= 8'h65) else $error("output trim too big");
   a_trim_i_cap: assert property (TRIM_ILIM <= 8'h65) else $error("limit trim too big");
   a_trim_restore: assert property ($rose(RST_N) |=>
      TRIM_VOUT == (NV_TRIM_VOUT > 8'h65 ? 8'h65 : NV_TRIM_VOUT)) else $error("trim not restored");
   a_nv_one_pulse: assert property ($rose(NV_WR_VOUT) |-> s_nv_strobe) else $error("long strobe");
   a_rdata_idle: assert property (s_no_rd |=> HRDATA == 32'h0) else $error("stray read data");
   a_ahb_okay: assert property (HREADYOUT && !HRESP) else $error("bus not okay");
   a_sda_open: assert property (SDA_O == 1'b0) else $error("data pin driven high");
   // Pull moves only while SCL low
   a_sda_stable: assert property (SCL_I && $past(SCL_I) |-> $stable(SDA_OE))
      else $error("data pull changed while clock high");
endmodule : psu_cmd_props

bind psu_cmd_slave psu_cmd_props chk_u (.*);

`default_nettype wire

// ===== verif/psu_host_model.sv
// Host controller model: bus master of the serial link.
// Assumes a pull-up on SDA; 1 on sda releases it.
`default_nettype none
// ==========================================
// Host master
module psu_host_model (
   // Clock and wire levels
   input  wire logic clk,
   input  wire logic sda_in,
   output var  logic scl,
   output var  logic sda
);
   timeunit 1ns;
   timeprecision 1ns;
   // Idle: both lines high
   initial begin
      scl = 1'b1;
      sda = 1'b1;
   end
   // Start or repeated start: SDA falls while SCL high
   task automatic start;
      @(posedge clk) sda <= 1'b1;
      repeat (4) @(posedge clk);
      scl <= 1'b1;
      repeat (4) @(posedge clk);
      sda <= 1'b0;
      repeat (4) @(posedge clk);
      scl <= 1'b0;
   endtask : start
   // Stop: SDA rises while SCL high, every frame ends this way
   task automatic stop;
      @(posedge clk) sda <= 1'b0;
      repeat (4) @(posedge clk);
      scl <= 1'b1;
      repeat (4) @(posedge clk);
      sda <= 1'b1;
   endtask : stop
   // Nine bits MSB first, sampled mid high
   task automatic xfer(input logic [8:0] d, output logic [8:0] q);
      for (int i = 8; i >= 0; i--) begin
         @(posedge clk) sda <= d[i];
         repeat (3) @(posedge clk);
         scl <= 1'b1;
         repeat (2) @(posedge clk);
         @(negedge clk) q[i] = sda_in;
         repeat (2) @(posedge clk);
         scl <= 1'b0;
      end
   endtask : xfer
endmodule : psu_host_model

`default_nettype wire

// ===== verif/test_psu_pmbus_command_slave.sv
// Self-checking bench of the bus command slave.
// Host model on serial pins, AHB tasks on registers.
`default_nettype none
// ==========================================
// Bench top
module test_psu_pmbus_command_slave
   import psu_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int unsigned T = 2000; // Short fan timer keeps the run brief
   logic        clk_sys = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, fan = 1'b0;
   logic [1:0]  htrans = 2'h0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
   logic [7:0]  nv_v = 8'hC8, nv_i = 8'h00, b [0:8];
   wire  logic  scl, sda_m, sda_oe, sda_w, hreadyout, nv_wr_v;
   wire  logic [7:0]  trim_v, trim_i;
   wire  logic [31:0] hrdata;
   int          seed = 32'hd3d99178, fails = 0, checked = 0, nv_cnt = 0;
   // Wired-and with pull-up
   assign sda_w = sda_m & ~sda_oe;
   always #50 clk_sys = ~clk_sys;
   always @(posedge clk_sys) if (nv_wr_v === 1'b1) nv_cnt++;
   psu_cmd_slave #(.FAN_WARN_CYC(T)) dut_u (.CLK_SYS(clk_sys), .RST_N(rst_n), .SCL_I(scl),
      .SDA_I(sda_w), .SDA_O(), .SDA_OE(sda_oe), .FAN_FAULT(fan), .NV_TRIM_VOUT(nv_v),
      .NV_TRIM_ILIM(nv_i), .NV_WR_VOUT(nv_wr_v), .NV_WR_ILIM(), .TRIM_VOUT(trim_v),
      .TRIM_ILIM(trim_i), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
      .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata),
      .HREADYOUT(hreadyout), .HRESP());
   psu_host_model host_u (.clk(clk_sys), .sda_in(sda_w), .scl(scl), .sda(sda_m));
   function automatic logic [7:0] sat(input logic [7:0] v);
      return (v > PSU_TRIM_MAX) ? PSU_TRIM_MAX : v;
   endfunction : sat
   task automatic chk(input string nm, input logic [31:0] seen, exp);
      checked++;
      if (seen !== exp) begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic summarize;
      $display("comparisons %0d mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : summarize
   // Bounded wait; ready and data as they stand at the rising edge
   task automatic rdy(output logic [31:0] r);
      logic ok;
      int n;
      n = 0;
      do begin
         @(negedge clk_sys);
         {ok, r} = {hreadyout, hrdata};
         @(posedge clk_sys);
         n++;
      end while (ok !== 1'b1 && n < 99);
      if (ok !== 1'b1) begin
         fails++;
         summarize;
      end
   endtask : rdy
   task automatic ahb(input logic w, input logic [31:0] a, d, output logic [31:0] r);
      @(posedge clk_sys);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      rdy(r);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      rdy(r);
   endtask : ahb
   // n 0: write byte; else Sr and n reads, last not acked
   task automatic smb(input logic [6:0] ad, input logic [7:0] cmd, input int n,
                      input logic [7:0] wd, output logic nak);
      logic [8:0] q;
      host_u.start;
      host_u.xfer({ad, 2'b01}, q);
      nak = q[0];
      host_u.xfer({cmd, 1'b1}, q);
      nak |= q[0];
      if (n == 0) begin
         host_u.xfer({wd, 1'b1}, q);
         nak |= q[0];
      end else begin
         host_u.start;
         host_u.xfer({ad, 2'b11}, q);
         nak |= q[0];
         for (int i = 0; i < n; i++) begin
            host_u.xfer({8'hFF, i == n - 1}, q);
            b[i] = q[8:1];
         end
      end
      host_u.stop;
   endtask : smb
   // Main sequence
   initial begin
      logic        nak;
      logic [15:0] tel [0:4];
      logic [7:0]  tv [0:5];
      logic [7:0]  rcmd [0:4];
      logic [7:0]  icmd [0:3];
      logic [63:0] ids [0:3];
      rcmd = '{PSU_CMD_VOUT, PSU_CMD_IOUT, PSU_CMD_TEMP, PSU_CMD_VCAP, PSU_CMD_FAN_SUPPLY};
      icmd = '{PSU_CMD_ID_MAKER, PSU_CMD_ID_MODEL, PSU_CMD_ID_REV, PSU_CMD_ID_SERIAL};
      ids = '{PSU_ID_MAKER, PSU_ID_MODEL, PSU_ID_REV, PSU_ID_SERIAL};
      tv = '{8'h66, 8'h66, 8'hFF, 8'h00, 8'($random(seed)), 8'($random(seed))};
      nv_i = 8'($random(seed)) & 8'h7F;
      repeat (20) @(posedge clk_sys);
      chk("trim default", trim_v, PSU_TRIM_NOMINAL);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk_sys);
      chk("trim_v restore", trim_v, sat(nv_v));
      chk("trim_i restore", trim_i, sat(nv_i));
      ahb(1'b0, 32'h1C, 32'h0, rd);
      chk("revision reg", rd, {24'h0, PSU_REV_RST});
      ahb(1'b0, 32'h40, 32'h0, rd);
      chk("unmapped reg", rd, 32'h0);
      for (int i = 0; i < 5; i++) begin
         tel[i] = 16'($random(seed));
         ahb(1'b1, 32'(4 * i), {16'h0, tel[i]}, rd);
         smb(PSU_ADDR_RST, rcmd[i], 2, 8'h00, nak);
         chk("word ack", nak, 1'b0);
         chk("word value", {b[1], b[0]}, tel[i]);
      end
      smb(PSU_ADDR_RST, PSU_CMD_PROTO_REV, 1, 8'h00, nak);
      chk("protocol rev", b[0], PSU_REV_RST);
      $display("telemetry test done");
      for (int k = 0; k < 4; k++) begin
         smb(PSU_ADDR_RST, icmd[k], 9, 8'h00, nak);
         chk("id count", b[0], 8'h08);
         for (int j = 1; j < 9; j++) chk("id char", b[j], ids[k][71 - 8 * j -: 8]);
      end
      $display("identity test done");
      for (int k = 0; k < 6; k++) begin
         smb(PSU_ADDR_RST, k[0] ? PSU_CMD_TRIM_ILIM : PSU_CMD_TRIM_VOUT, 0, tv[k], nak);
         chk("trim ack", nak, 1'b0);
         chk("trim value", k[0] ? trim_i : trim_v, sat(tv[k]));
      end
      chk("store strobes", nv_cnt, 3);
      smb(PSU_ADDR_RST, 8'h55, 0, 8'h00, nak);
      smb(PSU_ADDR_RST ^ 7'h01, PSU_CMD_TRIM_VOUT, 0, 8'h00, nak);
      chk("foreign address", nak, 1'b1);
      ahb(1'b0, 32'h18, 32'h0, rd);
      chk("trims kept", rd, {8'h0, sat(tv[5]), sat(tv[4]), 8'h00});
      $display("trim test done");
      fan <= 1'b1;
      for (int k = 0; k < 3; k++) begin
         repeat ((k == 1) ? 400 : 1600) @(posedge clk_sys);
         smb(PSU_ADDR_RST, PSU_CMD_FAN_STATUS, 1, 8'h00, nak);
         chk("fan status", b[0], {k == 2, 1'b0, k > 0, 5'h00});
      end
      fan <= 1'b0;
      smb(PSU_ADDR_RST, PSU_CMD_FAN_STATUS, 1, 8'h00, nak);
      chk("fan healthy", b[0], 8'h00);
      $display("fan test done");
      summarize;
   end
endmodule : test_psu_pmbus_command_slave

`default_nettype wire
